/* hw/afi_pkg.sv */
// Shared constants, register map and state codes for the format and identify command block.
package afi_pkg;
   // ==========================================
   // Command opcodes and feature code
   localparam logic [7:0] CMD_FMT_TRACK = 8'h50;
   localparam logic [7:0] CMD_FMT_UNIT = 8'hF7;
   localparam logic [7:0] CMD_ERASE_PREP = 8'hF3;
   localparam logic [7:0] CMD_IDENTIFY = 8'hEC;
   localparam logic [7:0] FMT_UNIT_FEATURE = 8'h11;
   // ==========================================
   // Status, error and device/head bit positions
   localparam int ST_BUSY = 7;
   localparam int ST_READY = 6;
   localparam int ST_SEEK = 4;
   localparam int ST_DRQ = 3;
   localparam int ST_ERR = 0;
   localparam int ER_ABORT = 2;
   localparam int DH_LBA = 6;
   localparam logic [7:0] STATUS_RESET = 8'h50;
   localparam logic [7:0] ERROR_RESET = 8'h00;
   localparam logic [7:0] DEVHEAD_RESET = 8'hA0;
   // ==========================================
   // Geometry, list depths and identify layout
   localparam logic [27:0] SPT = 28'h000003F;
   localparam logic [7:0] SPT_LAST = 8'h3E;
   localparam int DL_DEPTH = 8;
   localparam int RA_DEPTH = 4;
   localparam logic [7:0] ID_LAST = 8'hFF;
   localparam logic [15:0] ID_W0_HARD = 16'h045A;
   localparam logic [15:0] ID_W0_ALT = 16'h045E;
   localparam logic [15:0] ID_W2 = 16'h37C8;
   localparam logic [15:0] ID_W6 = 16'h003F;
   localparam logic [15:0] ID_W20 = 16'h0003;
   localparam logic [15:0] ID_W22 = 16'h0028;
   localparam logic [15:0] ID_W47 = 16'h8010;
   localparam logic [15:0] ID_W49 = 16'h0F00;
   localparam int ID_W49_STBY = 13;
   // ==========================================
   // Host controller register byte offsets
   localparam logic [11:0] REG_CMD = 12'h000;
   localparam logic [11:0] REG_FEATURE = 12'h004;
   localparam logic [11:0] REG_LBA = 12'h008;
   localparam logic [11:0] REG_DEVHEAD = 12'h00C;
   localparam logic [11:0] REG_STATUS = 12'h010;
   localparam int REG_ID_BIT = 10;
   localparam int DONE_BIT = 24;
   // ==========================================
   // Device sequencer states, one-hot
   typedef enum logic [4:0] {
      S_IDLE = 5'h01,
      S_TRACK = 5'h02,
      S_MERGE = 5'h04,
      S_INIT = 5'h08,
      S_XFER = 5'h10
   } afi_state_t;
endpackage

/* hw/afi_tf_if.sv */
// Task-file link between the host adapter end and the device end.
`timescale 1ns/1ps
interface afi_tf_if;
   // Host to device task file.
   logic cmd_valid;
   logic [7:0] cmd;
   logic [7:0] feature;
   logic [7:0] sect_num;
   logic [7:0] cyl_lo;
   logic [7:0] cyl_hi;
   logic [7:0] devhead;
   logic data_ack;
   // Device to host results.
   logic [7:0] error_flags;
   logic [7:0] status_flags;
   logic [7:0] devhead_ret;
   logic [15:0] data_word;
   logic done;
   modport dev (
      input cmd_valid, cmd, feature, sect_num, cyl_lo, cyl_hi, devhead, data_ack,
      output error_flags, status_flags, devhead_ret, data_word, done
   );
   modport host (
      output cmd_valid, cmd, feature, sect_num, cyl_lo, cyl_hi, devhead, data_ack,
      input error_flags, status_flags, devhead_ret, data_word, done
   );
endinterface

/* hw/afi_id_rom.sv */
// Identify data words 0 to 49; later words read as zero.
`timescale 1ns/1ps
module afi_id_rom #(
   parameter logic [15:0] CYLS = 16'h3FFF,
   parameter logic [15:0] HEADS = 16'h0010,
   parameter logic [15:0] BUF_BLOCKS = 16'h0100,
   parameter logic ALT_CLASS = 1'b0,
   parameter logic STBY_STD = 1'b1,
   parameter logic [159:0] SERIAL = {20{8'h20}},
   parameter logic [63:0] FWREV = {8{8'h20}},
   parameter logic [319:0] MODEL = {40{8'h20}}
) (
   // Word select and data.
   input wire logic [7:0] idx,
   output logic [15:0] word
);
   // ==========================================
   // Word lookup
   // Offsets into the three text fields, most significant pair first.
   logic [7:0] off_sn;
   logic [7:0] off_fw;
   logic [7:0] off_md;
   assign off_sn = idx - 8'h0A;
   assign off_fw = idx - 8'h17;
   assign off_md = idx - 8'h1B;

   // Selects the word; unlisted and reserved words give zero.
   always_comb
   begin
      word = 16'h0000;
      if (idx == 8'h00)
         word = ALT_CLASS ? afi_pkg::ID_W0_ALT : afi_pkg::ID_W0_HARD;
      else if (idx == 8'h01)
         word = CYLS;
      else if (idx == 8'h02)
         word = afi_pkg::ID_W2;
      else if (idx == 8'h03)
         word = HEADS;
      else if (idx == 8'h06)
         word = afi_pkg::ID_W6;
      else if (idx >= 8'h0A && idx <= 8'h13)
         word = SERIAL[159 - 16 * int'(off_sn) -: 16];
      else if (idx == 8'h14)
         word = afi_pkg::ID_W20;
      else if (idx == 8'h15)
         word = BUF_BLOCKS;
      else if (idx == 8'h16)
         word = afi_pkg::ID_W22;
      else if (idx >= 8'h17 && idx <= 8'h1A)
         word = FWREV[63 - 16 * int'(off_fw) -: 16];
      else if (idx >= 8'h1B && idx <= 8'h2E)
         word = MODEL[319 - 16 * int'(off_md) -: 16];
      else if (idx == 8'h2F)
         word = afi_pkg::ID_W47;
      else if (idx == 8'h31)
      begin
         word = afi_pkg::ID_W49;
         word[afi_pkg::ID_W49_STBY] = STBY_STD;
      end
      // words 4, 5, 7-9 and 48 stay zero by default.
   end
endmodule

/* hw/afi_dev.sv */
// Device end: format track, format unit, erase prepare and identify command execution.
//
// Contract
// - LBA mode packs sector, cylinders, head into LBA.
// - Format the one track holding the LBA.
// - Leave head field with LBA bits 24-27.
// - Out-of-range track LBA aborts the command.
// - Opcode F7h selects whole-unit format.
// - Host loads feature 11h only for format.
// - Merge reassigns into defects, clear, initialize.
// - New lists usable now, kept across reset.
// - Initialize LBA 0 to native maximum.
// - Format unit needs erase prepare just before.
// - Format unit never raises transfer request.
// - Host times out from identify word 89; word 89 reads zero here and afi_host has no timeout.
// - Opcode ECh sends one 256-word sector.
// - Word 0 reads 045AH or 045EH.
// - Word 2 reads 37C8H.
// - Words 1, 3, 6 give default geometry.
// - Serial, microcode, model returned as ASCII.
// - Words 20-22 give controller, buffer, check bytes.
// - Word 47 reads 8010H.
// - Word 49 reports timer and IORDY capabilities.
// - Words 4, 5, 7-9, 48 read zero.
//
// Added by the designer: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
module afi_dev #(
   parameter logic [27:0] NATIVE_MAX_LBA = 28'h0FFFFFF,
   parameter logic [15:0] CYLS = 16'h3FFF,
   parameter logic [15:0] HEADS = 16'h0010
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic sys_rst,
   // Task-file link.
   afi_tf_if.dev tf,
   // Reassignment reports from the media logic.
   input wire logic reassign_add,
   input wire logic [27:0] reassign_lba,
   // Media write requests, one sector per pulse.
   output logic media_wr_q,
   output logic [27:0] media_lba_q
);
   // ==========================================
   // Declarations
   localparam int DL_DEPTH = afi_pkg::DL_DEPTH;
   localparam int RA_DEPTH = afi_pkg::RA_DEPTH;
   afi_pkg::afi_state_t state_q;  // Sequencer state.
   logic [7:0] err_q;             // Error flags seen by the host.
   logic [7:0] stat_q;            // Status flags seen by the host.
   logic [7:0] dh_ret_q;          // Device/head value returned.
   logic done_q;                  // Completion pulse.
   logic prep_ok_q;               // Last command was erase prepare.
   logic [27:0] cur_q;            // Sector being initialized.
   logic [7:0] cnt_q;             // Track sector or list index.
   logic [7:0] id_idx_q;          // Identify word index.
   logic [7:0] id_idx_d;
   logic [15:0] rom_word;
   logic [15:0] data_q;           // Identify word on the link.
   logic [27:0] req_lba;          // Address from the task file.
   logic [27:0] trk_start;
   logic start;                   // Command taken this cycle.
   logic fin_ok;                  // Good completion this cycle.
   logic fin_abort;               // Aborted completion this cycle.
   logic dl_hit;                  // Current sector is a listed defect.
   logic [$clog2(DL_DEPTH)-1:0] dl_free;
   logic dl_has_free;
   logic [$clog2(RA_DEPTH)-1:0] ra_free;
   logic ra_has_free;
   // List storage models non-volatile media: blank at power-on, kept across reset.
   logic [27:0] dl_lba [DL_DEPTH];
   logic dl_vld [DL_DEPTH] = '{default: 1'b0};
   logic [27:0] ra_lba [RA_DEPTH];
   logic ra_vld [RA_DEPTH] = '{default: 1'b0};

   assign start = tf.cmd_valid && (state_q == afi_pkg::S_IDLE);

   // ==========================================
   // Address decode
   // Builds the target address from LBA fields or from cylinder and head.
   always_comb
   begin
      if (tf.devhead[afi_pkg::DH_LBA])
         req_lba = {tf.devhead[3:0], tf.cyl_hi, tf.cyl_lo, tf.sect_num};
      else
         req_lba = 28'(({tf.cyl_hi, tf.cyl_lo} * HEADS + tf.devhead[3:0]) * afi_pkg::SPT);
   end

   assign trk_start = req_lba - (req_lba % afi_pkg::SPT);

   // ==========================================
   // Defect and reassignment list lookups
   // Finds free slots and checks the current sector against the defects.
   always_comb
   begin
      dl_hit = 1'b0;
      dl_free = '0;
      dl_has_free = 1'b0;
      ra_free = '0;
      ra_has_free = 1'b0;
      for (int i = DL_DEPTH - 1; i >= 0; i--)
      begin
         if (dl_vld[i] && dl_lba[i] == cur_q)
            dl_hit = 1'b1;
         if (!dl_vld[i])
         begin
            dl_free = i[$clog2(DL_DEPTH)-1:0];
            dl_has_free = 1'b1;
         end
      end
      for (int j = RA_DEPTH - 1; j >= 0; j--)
      begin
         if (!ra_vld[j])
         begin
            ra_free = j[$clog2(RA_DEPTH)-1:0];
            ra_has_free = 1'b1;
         end
      end
   end

   // ==========================================
   // Command decode and completion
   // Decides the end of each command for this cycle.
   always_comb
   begin
      fin_ok = 1'b0;
      fin_abort = 1'b0;
      if (start)
      begin
         unique case (tf.cmd)
            afi_pkg::CMD_FMT_TRACK: fin_abort = (req_lba > NATIVE_MAX_LBA);
            afi_pkg::CMD_FMT_UNIT: fin_abort = !prep_ok_q;
            afi_pkg::CMD_ERASE_PREP: fin_ok = 1'b1;
            afi_pkg::CMD_IDENTIFY: fin_ok = 1'b0;
            default: fin_abort = 1'b1;
         endcase
      end
      else if (state_q == afi_pkg::S_TRACK)
         fin_ok = (cnt_q == afi_pkg::SPT_LAST);
      else if (state_q == afi_pkg::S_INIT)
         fin_ok = (cur_q == NATIVE_MAX_LBA);
      else if (state_q == afi_pkg::S_XFER)
         fin_ok = tf.data_ack && (id_idx_q == afi_pkg::ID_LAST);
   end

   // ==========================================
   // Sequencer
   // Walks each command through its phases.
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_q <= afi_pkg::S_IDLE;
         cnt_q <= 8'h00;
         cur_q <= 28'h0000000;
      end
      else
      begin
         unique case (state_q)
            afi_pkg::S_IDLE:
            begin
               cnt_q <= 8'h00;
               cur_q <= trk_start;
               if (start && !fin_abort && !fin_ok)
               begin
                  if (tf.cmd == afi_pkg::CMD_FMT_UNIT)
                     state_q <= afi_pkg::S_MERGE;
                  else if (tf.cmd == afi_pkg::CMD_IDENTIFY)
                     state_q <= afi_pkg::S_XFER;
                  else
                     state_q <= afi_pkg::S_TRACK;
               end
            end
            afi_pkg::S_TRACK:
            begin
               cnt_q <= cnt_q + 8'h01;
               cur_q <= cur_q + 28'h0000001;
               if (fin_ok)
                  state_q <= afi_pkg::S_IDLE;
            end
            afi_pkg::S_MERGE:
            begin
               cnt_q <= cnt_q + 8'h01;
               cur_q <= 28'h0000000;
               if (cnt_q == 8'(RA_DEPTH - 1))
                  state_q <= afi_pkg::S_INIT;
            end
            afi_pkg::S_INIT:
            begin
               cur_q <= cur_q + 28'h0000001;
               if (fin_ok)
                  state_q <= afi_pkg::S_IDLE;
            end
            afi_pkg::S_XFER:
            begin
               if (fin_ok)
                  state_q <= afi_pkg::S_IDLE;
            end
         endcase
      end
   end

   // ==========================================
   // List maintenance
   // Merges reassigned sectors into the defect list, then clears them.
   always_ff @(posedge core_clk)
   begin
      if (state_q == afi_pkg::S_MERGE && ra_vld[cnt_q[$clog2(RA_DEPTH)-1:0]])
      begin
         if (dl_has_free)
         begin
            dl_lba[dl_free] <= ra_lba[cnt_q[$clog2(RA_DEPTH)-1:0]];
            dl_vld[dl_free] <= 1'b1;
         end
         ra_vld[cnt_q[$clog2(RA_DEPTH)-1:0]] <= 1'b0;
      end
      // A new report outside the merge lands in a free slot.
      if (reassign_add && ra_has_free && state_q != afi_pkg::S_MERGE)
      begin
         ra_lba[ra_free] <= reassign_lba;
         ra_vld[ra_free] <= 1'b1;
      end
   end

   // ==========================================
   // Media writes
   // Issues one zero-fill sector write per cycle; unit initialize skips listed defects, track format writes them.
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         media_wr_q <= 1'b0;
         media_lba_q <= 28'h0000000;
      end
      else
      begin
         // new defect list used at once
         media_wr_q <= (state_q == afi_pkg::S_TRACK) || (state_q == afi_pkg::S_INIT && !dl_hit);
         media_lba_q <= cur_q;
      end
   end

   // ==========================================
   // Erase prepare tracking
   // Any taken command other than erase prepare cancels the permission.
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         prep_ok_q <= 1'b0;
      else if (start)
         prep_ok_q <= (tf.cmd == afi_pkg::CMD_ERASE_PREP);
   end

   // ==========================================
   // Task-file results
   // Updates status, error and device/head as commands start and end.
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         stat_q <= afi_pkg::STATUS_RESET;
         err_q <= afi_pkg::ERROR_RESET;
         dh_ret_q <= afi_pkg::DEVHEAD_RESET;
         done_q <= 1'b0;
      end
      else
      begin
         done_q <= fin_ok || fin_abort;
         if (start)
         begin
            err_q <= afi_pkg::ERROR_RESET;
            stat_q[afi_pkg::ST_ERR] <= 1'b0;
            stat_q[afi_pkg::ST_BUSY] <= !(fin_ok || fin_abort);
         end
         stat_q[afi_pkg::ST_DRQ] <= (state_q == afi_pkg::S_XFER) && !fin_ok;
         if (fin_abort)
         begin
            err_q[afi_pkg::ER_ABORT] <= 1'b1;
            stat_q[afi_pkg::ST_ERR] <= 1'b1;
            stat_q[afi_pkg::ST_BUSY] <= 1'b0;
         end
         else if (fin_ok)
            stat_q[afi_pkg::ST_BUSY] <= 1'b0;
         // head field from LBA bits 24-27
         if (state_q == afi_pkg::S_TRACK && fin_ok)
            dh_ret_q <= {tf.devhead[7:4], media_lba_q[27:24]};
         else if (start)
            dh_ret_q <= tf.devhead;
      end
   end

   // ==========================================
   // Identify data path
   // Steps the word index on each host acknowledge.
   always_comb
   begin
      id_idx_d = id_idx_q;
      if (start)
         id_idx_d = 8'h00;
      else if (state_q == afi_pkg::S_XFER && tf.data_ack)
         id_idx_d = id_idx_q + 8'h01;
   end

   // Holds the index and the word it selects.
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         id_idx_q <= 8'h00;
         data_q <= 16'h0000;
      end
      else
      begin
         id_idx_q <= id_idx_d;
         data_q <= rom_word;
      end
   end

   afi_id_rom #(
      .CYLS(CYLS),
      .HEADS(HEADS)
   ) u_rom (
      .idx(id_idx_d),
      .word(rom_word)
   );

   assign tf.error_flags = err_q;
   assign tf.status_flags = stat_q;
   assign tf.devhead_ret = dh_ret_q;
   assign tf.data_word = data_q;
   assign tf.done = done_q;
endmodule

/* hw/afi_host.sv */
// Host adapter end: Avalon-MM command registers driving the task-file link.
`timescale 1ns/1ps
module afi_host (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic sys_rst,
   // Avalon-MM slave.
   input wire logic [11:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Task-file link.
   afi_tf_if.host tf
);
   // ==========================================
   // Declarations
   logic wait_q;            // Waitrequest, low for one cycle per access.
   logic [31:0] rdata_q;    // Read data.
   logic [7:0] cmd_q;       // Opcode sent.
   logic cmd_vld_q;         // Command pulse.
   logic [7:0] feat_q;      // Feature value.
   logic [27:0] lba_q;      // Address fields.
   logic [7:0] dh_q;        // Upper device/head bits.
   logic ack_q;             // Word acknowledge.
   logic done_seen_q;       // Sticky completion.
   logic [7:0] cap_idx_q;   // Next identify word slot.
   logic [15:0] id_mem [256];
   logic req;
   logic wr_now;

   assign req = avs_read || avs_write;
   // Writes take effect at the edge the master sees waitrequest low.
   assign wr_now = avs_write && !wait_q;

   // ==========================================
   // Bus handshake
   // Answers every access on the second cycle.
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         wait_q <= 1'b1;
      else
         wait_q <= !(req && wait_q);
   end

   // Returns status, controls or a captured identify word.
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         rdata_q <= 32'h00000000;
      else if (avs_read && wait_q)
      begin
         if (avs_address[afi_pkg::REG_ID_BIT])
            rdata_q <= {16'h0000, id_mem[avs_address[9:2]]};
         else if (avs_address == afi_pkg::REG_FEATURE)
            rdata_q <= {24'h000000, feat_q};
         else if (avs_address == afi_pkg::REG_LBA)
            rdata_q <= {4'h0, lba_q};
         else if (avs_address == afi_pkg::REG_DEVHEAD)
            rdata_q <= {24'h000000, dh_q};
         else if (avs_address == afi_pkg::REG_STATUS)
            rdata_q <= {7'h00, done_seen_q, tf.devhead_ret, tf.error_flags, tf.status_flags};
         else
            rdata_q <= 32'h00000000;
      end
   end

   // ==========================================
   // Task-file registers
   // Holds address and feature fields; a command write sends one pulse.
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cmd_q <= 8'h00;
         cmd_vld_q <= 1'b0;
         feat_q <= 8'h00;
         lba_q <= 28'h0000000;
         dh_q <= afi_pkg::DEVHEAD_RESET;
      end
      else
      begin
         cmd_vld_q <= wr_now && avs_address == afi_pkg::REG_CMD;
         if (wr_now && avs_address == afi_pkg::REG_CMD)
            cmd_q <= avs_writedata[7:0];
         // software writes the format feature code
         if (wr_now && avs_address == afi_pkg::REG_FEATURE)
            feat_q <= avs_writedata[7:0];
         if (wr_now && avs_address == afi_pkg::REG_LBA)
            lba_q <= avs_writedata[27:0];
         if (wr_now && avs_address == afi_pkg::REG_DEVHEAD)
            dh_q <= avs_writedata[7:0];
      end
   end

   // ==========================================
   // Completion and identify capture
   // Completion sticks until the next command write; a new one wins.
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         done_seen_q <= 1'b0;
      else if (tf.done)
         done_seen_q <= 1'b1;
      else if (wr_now && avs_address == afi_pkg::REG_CMD)
         done_seen_q <= 1'b0;
   end

   // take each word while the device requests transfer
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ack_q <= 1'b0;
         cap_idx_q <= 8'h00;
      end
      else
      begin
         ack_q <= tf.status_flags[afi_pkg::ST_DRQ] && !ack_q;
         if (cmd_vld_q)
            cap_idx_q <= 8'h00;
         else if (tf.status_flags[afi_pkg::ST_DRQ] && !ack_q)
            cap_idx_q <= cap_idx_q + 8'h01;
      end
   end

   // Stores the word being acknowledged.
   always_ff @(posedge core_clk)
   begin
      if (tf.status_flags[afi_pkg::ST_DRQ] && !ack_q)
         id_mem[cap_idx_q] <= tf.data_word;
   end

   // address fields split for LBA mode
   assign tf.sect_num = lba_q[7:0];
   assign tf.cyl_lo = lba_q[15:8];
   assign tf.cyl_hi = lba_q[23:16];
   assign tf.devhead = {dh_q[7:4], lba_q[27:24]};
   assign tf.cmd = cmd_q;
   assign tf.cmd_valid = cmd_vld_q;
   assign tf.feature = feat_q;
   assign tf.data_ack = ack_q;
   assign avs_readdata = rdata_q;
   assign avs_waitrequest = wait_q;
endmodule

/* test/afi_sva.sv */
// Assertions on the task-file link between the two ends.
`timescale 1ns/1ps
module afi_sva (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic sys_rst,
   // Link signals.
   input wire logic cmd_valid,
   input wire logic [7:0] cmd,
   input wire logic [7:0] status_flags,
   input wire logic [7:0] error_flags,
   input wire logic [15:0] data_word,
   input wire logic done
);
   // ==========
   // Properties
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // A command is taken only while the device is not busy.
   wire logic take = cmd_valid && !status_flags[7];
   property p_abort; done && error_flags[2] |-> status_flags[0] && !status_flags[7]; endproperty
   a_abort: assert property (p_abort) else $error("abort status wrong");
   property p_idle; done |-> !status_flags[7] && !status_flags[3]; endproperty
   a_idle: assert property (p_idle) else $error("busy at completion");
   property p_take; take |-> ##[1:2] (status_flags[7] || done); endproperty
   a_take: assert property (p_take) else $error("command not started");
   property p_bad; take && cmd == 8'h00 |-> ##[1:2] (done && error_flags[2]); endproperty
   a_bad: assert property (p_bad) else $error("unknown opcode not aborted");
   property p_track; take && cmd == afi_pkg::CMD_FMT_TRACK |-> ##[1:66] done; endproperty
   a_track: assert property (p_track) else $error("track format too long");
   property p_unit; take && cmd == afi_pkg::CMD_FMT_UNIT |=> !status_flags[3] [*8]; endproperty
   a_unit: assert property (p_unit) else $error("unit format raised drq");
   property p_ident; take && cmd == afi_pkg::CMD_IDENTIFY |-> ##2 status_flags[3]; endproperty
   a_ident: assert property (p_ident) else $error("identify gave no drq");
   property p_w0; $rose(status_flags[3]) |-> data_word == afi_pkg::ID_W0_HARD; endproperty
   a_w0: assert property (p_w0) else $error("first word wrong");
   property p_end; $fell(status_flags[3]) |-> done; endproperty
   a_end: assert property (p_end) else $error("drq fell without done");
   c_abort: cover property (done && error_flags[2]);
   c_ok: cover property (done && !error_flags[2]);
   c_ident: cover property ($rose(status_flags[3]));
endmodule

/* test/afi_bench.sv */
// Bench driving the host end over Avalon-MM against the device end.
`timescale 1ns/1ps
module afi_bench;
   // ==========
   // Signals
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [11:0] avs_address = 12'h000;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic reassign_add = 1'b0;
   logic [27:0] reassign_lba = 28'h0000010;
   logic media_wr_q;
   logic [27:0] media_lba_q;
   logic [31:0] rd;
   logic [31:0] wcnt = 32'h00000000;
   logic [31:0] hcnt = 32'h00000000;
   logic [31:0] w0;
   logic [27:0] wlast;
   int fails = 0;
   int checked = 0;
   afi_tf_if tf ();
   afi_host i_afi_host (.core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .tf(tf));
   afi_dev #(.NATIVE_MAX_LBA(28'h0000040)) i_afi_dev (.core_clk(core_clk), .sys_rst(sys_rst),
      .tf(tf), .reassign_add(reassign_add), .reassign_lba(reassign_lba),
      .media_wr_q(media_wr_q), .media_lba_q(media_lba_q));
   afi_sva i_afi_sva (.core_clk(core_clk), .sys_rst(sys_rst), .cmd_valid(tf.cmd_valid),
      .cmd(tf.cmd), .status_flags(tf.status_flags), .error_flags(tf.error_flags),
      .data_word(tf.data_word), .done(tf.done));
   initial
   begin
      forever #10 core_clk = ~core_clk;
   end
   // Counts media writes and those that hit the reassigned sector.
   always @(posedge core_clk)
   begin
      if (media_wr_q === 1'b1)
      begin
         wcnt <= wcnt + 1;
         wlast <= media_lba_q;
         hcnt <= hcnt + (media_lba_q === 28'h0000010);
      end
   end
   // ==========
   // Tasks
   task finish_test;
      $display("Compared %0d, mismatched %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e)
      begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   // One Avalon access held until waitrequest is sampled low.
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 50);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge core_clk);
      if (n >= 50)
      begin
         fails++;
         finish_test;
      end
   endtask
   // Loads the task file, issues a command and polls for completion.
   task issue(input logic [7:0] op, input logic [7:0] f, input logic [27:0] l);
      int n;
      n = 0;
      bus(1'b1, afi_pkg::REG_FEATURE, {24'h000000, f});
      bus(1'b1, afi_pkg::REG_LBA, {4'h0, l});
      bus(1'b1, afi_pkg::REG_DEVHEAD, 32'h000000E0);
      bus(1'b1, afi_pkg::REG_CMD, {24'h000000, op});
      do
      begin
         bus(1'b0, afi_pkg::REG_STATUS, 32'h00000000);
         n++;
      end
      while (rd[24] !== 1'b1 && n < 400);
      if (n >= 400)
      begin
         fails++;
         finish_test;
      end
   endtask
   task t_track;
      w0 = wcnt;
      issue(8'h50, 8'h00, 28'h0000005);
      chk({8'h00, rd[23:0]}, 32'h00E00050);
      chk(wcnt - w0, 32'h0000003F);
      chk({4'h0, wlast}, 32'h0000003E);
   endtask
   task t_abort;
      issue(8'h50, 8'h00, 28'h0000041);
      chk({16'h0000, rd[15:0]}, 32'h00000451);
      issue(8'hF7, 8'h11, 28'h0000000);
      chk({16'h0000, rd[15:0]}, 32'h00000451);
      issue(8'h00, 8'h00, 28'h0000000);
      chk({16'h0000, rd[15:0]}, 32'h00000451);
   endtask
   task t_unit;
      reassign_add <= 1'b1;
      @(posedge core_clk);
      reassign_add <= 1'b0;
      w0 = hcnt;
      repeat (2)
      begin
         issue(8'hF3, 8'h00, 28'h0000000);
         issue(8'hF7, 8'h11, 28'h0000000);
         chk({16'h0000, rd[15:0]}, 32'h00000050);
         chk({4'h0, wlast}, 32'h00000040);
         chk(hcnt - w0, 32'h00000000);
      end
   endtask
   function automatic logic [15:0] exp_w(input int i);
      case (i)
         0: return 16'h045A;
         1: return 16'h3FFF;
         2: return 16'h37C8;
         3: return 16'h0010;
         6: return 16'h003F;
         20: return 16'h0003;
         21: return 16'h0100;
         22: return 16'h0028;
         47: return 16'h8010;
         49: return 16'h2F00;
         default: return (i >= 10 && i <= 46) ? 16'h2020 : 16'h0000;
      endcase
   endfunction
   task t_ident;
      issue(8'hEC, 8'h00, 28'h0000000);
      chk({16'h0000, rd[15:0]}, 32'h00000050);
      for (int i = 0; i < 51; i++)
      begin
         bus(1'b0, 12'h400 + 12'(4 * i), 32'h00000000);
         chk(rd, {16'h0000, exp_w(i)});
      end
   endtask
   initial
   begin
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      bus(1'b0, afi_pkg::REG_STATUS, 32'h00000000);
      chk(rd, 32'h00A00050);
      t_track;
      t_abort;
      t_unit;
      t_ident;
      finish_test;
   end
endmodule
